// file: rtl/dftr_pkg.sv
package dftr_pkg;

   // Trip codes reported on the fault code output
   localparam logic [7:0] CODE_NONE = 8'h00;
   localparam logic [7:0] CODE_OC_INST = 8'h03;
   localparam logic [7:0] CODE_OVERLOAD = 8'h04;
   localparam logic [7:0] CODE_OC_CODE5 = 8'h05;
   localparam logic [7:0] CODE_EXT_TRIP = 8'h0B;
   localparam logic [7:0] CODE_RIPPLE = 8'h0D;
   localparam logic [7:0] CODE_PHASE_LOSS = 8'h0E;
   localparam logic [7:0] CODE_HW_OC = 8'h0F;
   localparam logic [7:0] CODE_HS_THERM = 8'h10;
   localparam logic [7:0] CODE_MEM_IO = 8'h11;
   localparam logic [7:0] CODE_LOOP_LOST = 8'h12;
   localparam logic [7:0] CODE_MEM_DSP = 8'h13;
   localparam logic [7:0] CODE_MOTOR_PTC = 8'h15;
   localparam logic [7:0] CODE_FAN = 8'h16;
   localparam logic [7:0] CODE_OVERTEMP = 8'h17;
   localparam logic [7:0] CODE_OUT_FAULT = 8'h1A;
   localparam logic [7:0] CODE_AUTOTUNE = 8'h29;
   localparam logic [7:0] CODE_REG_LINK = 8'h32;
   localparam logic [7:0] CODE_BUS_LINK = 8'h33;

   // Lockout, warm-up and link timeout constants, and reset values
   localparam int CLK_HZ = 200_000_000;
   localparam int LOCK_BASE_S = 2;
   localparam int LOCK_MAX_LEVEL = 5;
   localparam logic [2:0] LEVEL_RESET = 3'h0;
   localparam logic [1:0] WARM_RESET = 2'h0;
   localparam logic [1:0] WARM_CYCLES = 2'h3;
   localparam int LINK_TIMEOUT_MS = 1000;
   localparam logic [7:0] CODE_RESET = 8'h00;

   // Fault condition inputs, each a level from the sensing logic
   typedef struct packed {
      logic outOvercurrent;
      logic motorOverload;
      logic extTripOpen;
      logic busRipple;
      logic phaseLoss;
      logic hwOvercurrent;
      logic heatsinkTherm;
      logic memFaultIo;
      logic loopSignalLost;
      logic memFaultDsp;
      logic motorPtc;
      logic fanFail;
      logic internalOvertemp;
      logic outputFault;
      logic autotuneFail;
   } dftr_faults_t;

   // Reset request sources
   typedef struct packed {
      logic powerGood;
      logic enableIn;
      logic stopKey;
      logic ctrlResetBit;
   } dftr_reset_src_t;

   typedef enum logic [1:0] {
      LINK_NONE,
      LINK_REGISTER,
      LINK_FIELDBUS
   } dftr_link_t;

   typedef enum logic [1:0] {
      ST_RUN,
      ST_TRIPPED,
      ST_LOCKED
   } dftr_state_t;

endpackage : dftr_pkg

// file: rtl/dftr_trip_manager.sv
// Overview of operation
// RL1: Report 13 for bus ripple and 14 for input phase loss.
// RL2: Report 15 for hardware output overcurrent, 26 for output fault.
// RL3: Report 16 heatsink thermistor, 22 fan failure, 23 internal overtemp.
// RL4: Report 17 for IO memory fault, 19 for DSP memory fault.
// RL5: Trip with 18 when the current-loop input is lost.
// RL6: Trip with 21 on motor PTC over-temperature.
// RL7: Trip with 41 when autotune motor parameters are wrong.
// RL8: Register link needs a poll within timeout, else trip 50.
// RL9: Fieldbus link needs cyclic traffic within timeout, else trip 51.
// RL10: After codes 3, 4, 5 or 15 refuse resets until lockout ends.
// RL11: Power removed then restored clears a latched trip.
// RL12: Enable input removed then reapplied requests a reset.
// RL13: Stop/reset key press requests a reset.
// RL14: Control-word reset bit rising 0 to 1 requests a reset; taken only while linkMode is not LINK_NONE.
// RL15: Lockout 2, 4, 8, 16, 32 s, then 64 s for later trips.
// RL16: Requests during lockout are dropped; trip counter saturates.
// RL17: Code 00 means no fault; code 03 instantaneous overcurrent.
// RL18: Code 04 after sustained current above rated motor setting.
// RL19: Code 11 when the external trip contact on input 3 opens.
`timescale 1ns/1ps
`default_nettype none
module dftr_trip_manager
   import dftr_pkg::*;
#(
   parameter int LOCK_BASE_CYCLES = LOCK_BASE_S * CLK_HZ,
   parameter int LINK_TIMEOUT_CYCLES = LINK_TIMEOUT_MS * (CLK_HZ / 1000)
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Fault sensing levels from the pins
   input wire dftr_pkg::dftr_faults_t faultsIn,
   // Reset request sources from the pins
   input wire dftr_pkg::dftr_reset_src_t resetSrcIn,
   // Control link supervision
   input wire dftr_pkg::dftr_link_t linkMode,
   input wire logic linkActivity,
   // Status
   output logic [7:0] faultCode,
   output logic tripped,
   output logic lockoutActive,
   output logic resetRefused
);
   import dftr_pkg::*;

   // Refuse counts the counters cannot hold
   if (LOCK_BASE_CYCLES < 1) begin : g_bad_lock
      $error("dftr_trip_manager: lockout base must be at least one cycle");
   end
   if (LINK_TIMEOUT_CYCLES < 1) begin : g_bad_link
      $error("dftr_trip_manager: link timeout must be at least one cycle");
   end
   if (LOCK_MAX_LEVEL > 7) begin : g_bad_level
      $error("dftr_trip_manager: trip level must fit three bits");
   end

   // Two-stage synchronisers for every pin input except linkMode
   localparam int NSYNC = $bits(dftr_faults_t) + $bits(dftr_reset_src_t) + 1;
   logic [NSYNC-1:0] syncA_reg;
   logic [NSYNC-1:0] syncB_reg;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         syncA_reg <= '0;
      end else begin
         syncA_reg <= {faultsIn, resetSrcIn, linkActivity};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         syncB_reg <= '0;
      end else begin
         syncB_reg <= syncA_reg;
      end
   end

   dftr_faults_t flt;
   dftr_reset_src_t rsrc;
   logic linkAct;
   assign {flt, rsrc, linkAct} = syncB_reg;

   // Previous values for edge detection on reset sources and link activity
   dftr_reset_src_t rsrcPrev_reg;
   logic linkActPrev_reg;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rsrcPrev_reg <= '0;
      end else begin
         rsrcPrev_reg <= rsrc;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         linkActPrev_reg <= 1'b0;
      end else begin
         linkActPrev_reg <= linkAct;
      end
   end

   // Edges ignored until syncs and history hold pin values, else a
   // high idle level reads as a request right after reset
   logic [1:0] warm_reg;
   logic warmDone;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         warm_reg <= WARM_RESET;
      end else if (!warmDone) begin
         warm_reg <= warm_reg + 2'h1;
      end
   end
   assign warmDone = warm_reg == WARM_CYCLES;

   // Rising edge of a synchronised level against its history
   function automatic logic rise_edge(input logic now, input logic prev);
      return now & ~prev;
   endfunction : rise_edge

   logic powerUp;
   logic resetReq;
   // Power restore is a rising edge of the supply-good level
   assign powerUp = warmDone
      & rise_edge(rsrc.powerGood, rsrcPrev_reg.powerGood); // [RL11]
   // Enable reapplied, after its removal, as a rising edge
   assign resetReq = warmDone
      & (rise_edge(rsrc.enableIn, rsrcPrev_reg.enableIn) // [RL12]
         | rise_edge(rsrc.stopKey, rsrcPrev_reg.stopKey) // [RL13]
         | (rise_edge(rsrc.ctrlResetBit, rsrcPrev_reg.ctrlResetBit)
            & (linkMode != LINK_NONE))); // [RL14]

   // Link watchdog: any activity edge restarts the count
   logic [31:0] linkCnt_reg;
   logic linkTimeout;
   always_ff @(posedge sys_clk) begin
      if (rst || linkMode == LINK_NONE || (linkAct ^ linkActPrev_reg)) begin
         linkCnt_reg <= '0;
      end else if (!linkTimeout) begin
         linkCnt_reg <= linkCnt_reg + 32'h0000_0001;
      end
   end
   assign linkTimeout = linkCnt_reg >= 32'(LINK_TIMEOUT_CYCLES);

   // Link loss only counts while that link is the control source
   function automatic logic [7:0] link_code(input logic lt,
                                            input dftr_link_t lm);
      logic [7:0] c;
      c = CODE_NONE;
      if (lt) begin
         case (lm)
            LINK_REGISTER: c = CODE_REG_LINK; // [RL8]
            LINK_FIELDBUS: c = CODE_BUS_LINK; // [RL9]
            default: c = CODE_NONE;
         endcase
      end
      return c;
   endfunction : link_code

   // Priority encode: earliest listed condition wins
   function automatic logic [7:0] pick_code(input dftr_faults_t f,
                                            input logic lt,
                                            input dftr_link_t lm);
      logic [7:0] c;
      c = CODE_NONE; // [RL17]
      if (f.hwOvercurrent) c = CODE_HW_OC; // [RL2]
      else if (f.outOvercurrent) c = CODE_OC_INST; // [RL17]
      else if (f.motorOverload) c = CODE_OVERLOAD; // [RL18]
      else if (f.outputFault) c = CODE_OUT_FAULT; // [RL2]
      else if (f.busRipple) c = CODE_RIPPLE; // [RL1]
      else if (f.phaseLoss) c = CODE_PHASE_LOSS; // [RL1]
      else if (f.heatsinkTherm) c = CODE_HS_THERM; // [RL3]
      else if (f.fanFail) c = CODE_FAN; // [RL3]
      else if (f.internalOvertemp) c = CODE_OVERTEMP; // [RL3]
      else if (f.memFaultIo) c = CODE_MEM_IO; // [RL4]
      else if (f.memFaultDsp) c = CODE_MEM_DSP; // [RL4]
      else if (f.loopSignalLost) c = CODE_LOOP_LOST; // [RL5]
      else if (f.motorPtc) c = CODE_MOTOR_PTC; // [RL6]
      else if (f.autotuneFail) c = CODE_AUTOTUNE; // [RL7]
      else if (f.extTripOpen) c = CODE_EXT_TRIP; // [RL19]
      else c = link_code(lt, lm); // [RL8] [RL9]
      return c;
   endfunction : pick_code

   function automatic logic is_lock_code(input logic [7:0] c);
      return c == CODE_OC_INST || c == CODE_OVERLOAD
         || c == CODE_OC_CODE5 || c == CODE_HW_OC; // [RL10]
   endfunction : is_lock_code

   logic [7:0] newCode;
   assign newCode = pick_code(flt, linkTimeout, linkMode);

   // Trip state and latched code
   dftr_state_t state_reg;
   logic [7:0] code_reg;
   logic [2:0] level_reg;
   logic [37:0] lockCnt_reg;
   logic lockDone;
   assign lockDone = lockCnt_reg == '0;

   // Lockout length doubles per trip up to the sixth level
   function automatic logic [37:0] lock_len(input logic [2:0] lvl);
      return 38'(LOCK_BASE_CYCLES) << lvl; // [RL15]
   endfunction : lock_len

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg <= ST_RUN;
      end else if (powerUp) begin
         // Full power cycle clears the trip but not the lockout count
         state_reg <= ST_RUN; // [RL11]
      end else begin
         case (state_reg)
            ST_RUN: begin
               if (newCode != CODE_NONE) begin
                  state_reg <= is_lock_code(newCode) ? ST_LOCKED
                                                     : ST_TRIPPED; // [RL10]
               end
            end
            ST_TRIPPED: begin
               if (resetReq) begin
                  state_reg <= ST_RUN;
               end
            end
            ST_LOCKED: begin
               // Requests are dropped, not remembered, while locked
               if (lockDone) begin
                  state_reg <= ST_TRIPPED; // [RL16]
               end
            end
            default: begin
               state_reg <= ST_RUN;
            end
         endcase
      end
   end

   // Latched code follows the same accept and clear events
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         code_reg <= CODE_RESET;
      end else if (powerUp) begin
         code_reg <= CODE_NONE; // [RL11]
      end else if (state_reg == ST_RUN && newCode != CODE_NONE) begin
         code_reg <= newCode; // [RL17]
      end else if (state_reg == ST_TRIPPED && resetReq) begin
         code_reg <= CODE_NONE;
      end
   end

   // A lockout starts on the edge that latches a lockout code
   logic lockStart;
   assign lockStart = state_reg == ST_RUN && !powerUp
      && is_lock_code(newCode); // [RL10]

   // Trip counter saturates so later trips all get the longest delay
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         level_reg <= LEVEL_RESET;
      end else if (lockStart && level_reg < 3'(LOCK_MAX_LEVEL)) begin
         level_reg <= level_reg + 3'h1; // [RL16]
      end
   end

   // Keeps counting through a power cycle, though the power cycle still ends ST_LOCKED at once
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lockCnt_reg <= '0;
      end else if (lockStart) begin
         lockCnt_reg <= lock_len(level_reg); // [RL15]
      end else if (!lockDone) begin
         lockCnt_reg <= lockCnt_reg - 38'h00_0000_0001;
      end
   end

   // Registered outputs, one flop each
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         faultCode <= CODE_RESET;
      end else begin
         faultCode <= code_reg;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tripped <= 1'b0;
      end else begin
         tripped <= state_reg != ST_RUN;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lockoutActive <= 1'b0;
      end else begin
         lockoutActive <= state_reg == ST_LOCKED;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         resetRefused <= 1'b0;
      end else begin
         resetRefused <= state_reg == ST_LOCKED && resetReq; // [RL10]
      end
   end

endmodule : dftr_trip_manager
`default_nettype wire

// file: dv/dftr_trip_manager_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dftr_trip_manager_sva
   import dftr_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Inputs
   input wire dftr_pkg::dftr_faults_t faultsIn,
   input wire dftr_pkg::dftr_reset_src_t resetSrcIn,
   input wire dftr_pkg::dftr_link_t linkMode,
   input wire logic linkActivity,
   // Status
   input wire logic [7:0] faultCode,
   input wire logic tripped,
   input wire logic lockoutActive,
   input wire logic resetRefused
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_code_flag_pair: assert property (
      tripped == (faultCode != 8'h00)) else $error("flag and code differ");
   a_code_held: assert property (
      tripped && $past(tripped) |-> $stable(faultCode))
      else $error("code moved while tripped");
   a_refuse_locked: assert property (
      resetRefused |-> lockoutActive || $past(lockoutActive))
      else $error("refusal outside lockout");
   a_refuse_single: assert property (
      resetRefused |=> !resetRefused) else $error("refusal too long");
   a_lock_cause: assert property (
      $rose(lockoutActive) |-> faultCode inside {8'h03, 8'h04, 8'h0F})
      else $error("lockout on wrong code");
   a_hwoc_trip: assert property (
      ($rose(faultsIn.hwOvercurrent) && !tripped && !lockoutActive)
      ##1 faultsIn.hwOvercurrent [*4] |-> faultCode == 8'h0F && lockoutActive)
      else $error("overcurrent not latched");
   a_reg_link: assert property (
      $rose(tripped) && faultCode == 8'h32 |-> linkMode == LINK_REGISTER)
      else $error("register link trip in wrong mode");
   a_bus_link: assert property (
      $rose(tripped) && faultCode == 8'h33 |-> linkMode == LINK_FIELDBUS)
      else $error("fieldbus trip in wrong mode");
   a_key_clears: assert property (
      $rose(resetSrcIn.stopKey) && tripped && !lockoutActive
      |-> ##[3:5] !tripped) else $error("key did not clear");
   a_link_fresh: assert property (
      $changed(linkActivity) |-> ##5 (!($rose(tripped)
      && faultCode inside {8'h32, 8'h33})) [*4])
      else $error("link trip despite activity");
endmodule : dftr_trip_manager_sva
bind dftr_trip_manager dftr_trip_manager_sva i_sva (.sys_clk(sys_clk),
   .rst(rst), .faultsIn(faultsIn), .resetSrcIn(resetSrcIn),
   .linkMode(linkMode), .linkActivity(linkActivity), .faultCode(faultCode),
   .tripped(tripped), .lockoutActive(lockoutActive),
   .resetRefused(resetRefused));
`default_nettype wire

// file: dv/dftr_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module dftr_master_model
   import dftr_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // Requests toward the block
   output var dftr_pkg::dftr_reset_src_t resetSrc,
   output logic linkActivity
);
   // Idle: power and enable high, key and control bit low
   initial begin
      resetSrc = 4'hC;
      linkActivity = 1'b0;
   end
   // Held four cycles so the input sync cannot miss it
   task automatic request(input int src);
      @(negedge sys_clk);
      resetSrc[src] = ~resetSrc[src];
      repeat (4) @(negedge sys_clk);
      resetSrc[src] = ~resetSrc[src];
   endtask : request
   // Ten cycles apart, well inside the link timeout
   task automatic poll(input int n);
      repeat (n) begin
         repeat (10) @(negedge sys_clk);
         linkActivity = ~linkActivity;
      end
   endtask : poll
endmodule : dftr_master_model
`default_nettype wire

// file: dv/dftr_trip_manager_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dftr_trip_manager_tb_top;
   import dftr_pkg::*;
   localparam int LOCK = 20;
   logic sys_clk, rst, tripped, lockoutActive, resetRefused, linkActivity;
   logic [7:0] faultCode;
   dftr_faults_t faultsIn;
   dftr_reset_src_t resetSrcIn;
   dftr_link_t linkMode;
   int error_cnt = 0;
   int checks = 0;
   logic [7:0] expCode [15] = '{8'h29, 8'h1A, 8'h17, 8'h16, 8'h15, 8'h13,
      8'h12, 8'h11, 8'h10, 8'h0F, 8'h0E, 8'h0D, 8'h0B, 8'h04, 8'h03};
   dftr_trip_manager #(.LOCK_BASE_CYCLES(LOCK), .LINK_TIMEOUT_CYCLES(50))
      i_dut (.sys_clk(sys_clk), .rst(rst), .faultsIn(faultsIn),
      .resetSrcIn(resetSrcIn), .linkMode(linkMode),
      .linkActivity(linkActivity), .faultCode(faultCode),
      .tripped(tripped), .lockoutActive(lockoutActive),
      .resetRefused(resetRefused));
   dftr_master_model i_mdl (.sys_clk(sys_clk), .resetSrc(resetSrcIn),
      .linkActivity(linkActivity));
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : cyc
   task automatic expect_true(input logic ok, input string what);
      checks++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask : expect_true
   task automatic tally_and_finish();
      $display("checks %0d, errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : tally_and_finish
   task automatic code_table();
      for (int i = 0; i < 13; i++) begin
         if (i == 9) continue;
         cyc(1);
         faultsIn[i] = 1'b1;
         cyc(6);
         expect_true(faultCode === expCode[i], "code");
         faultsIn[i] = 1'b0;
         i_mdl.request(3 - i % 3);
         cyc(6);
         expect_true(tripped === 1'b0, "clear");
      end
   endtask : code_table
   // Overcurrent ladder; the lockout doubles and then saturates
   task automatic lockout_ladder();
      int ocBit [3] = '{14, 13, 9};
      int n;
      int len;
      bit refused;
      for (int t = 0; t < 7; t++) begin
         n = 0;
         refused = 1'b0;
         len = LOCK << (t < 5 ? t : 5);
         cyc(1);
         faultsIn[ocBit[t % 3]] = 1'b1;
         cyc(6);
         faultsIn = '0;
         expect_true(lockoutActive === 1'b1, "no lockout");
         fork i_mdl.request(1); join_none
         while (lockoutActive === 1'b1 && n < len + 20) begin
            refused |= resetRefused;
            n++;
            cyc(1);
         end
         expect_true(n >= len - 5 && n <= len, "lockout length");
         if (n >= len + 20) tally_and_finish();
         expect_true(refused && faultCode === expCode[ocBit[t % 3]],
            "refusal");
         i_mdl.request(1);
         cyc(6);
         expect_true(faultCode === 8'h00, "no clear");
      end
   endtask : lockout_ladder
   // Power cycle clears a locked trip while the lockout still runs
   task automatic power_in_lockout();
      cyc(1);
      faultsIn[9] = 1'b1;
      cyc(6);
      faultsIn = '0;
      expect_true(lockoutActive === 1'b1, "no lockout");
      i_mdl.request(3);
      cyc(6);
      expect_true(tripped === 1'b0 && faultCode === 8'h00,
         "power cycle in lockout");
   endtask : power_in_lockout
   task automatic link_watch();
      for (int m = 1; m < 3; m++) begin
         fork i_mdl.poll(20); join_none
         cyc(5);
         linkMode = dftr_link_t'(m);
         cyc(140);
         expect_true(tripped === 1'b0, "polled link");
         cyc(150);
         expect_true(faultCode === (m == 1 ? 8'h32 : 8'h33),
            "link loss");
         fork i_mdl.poll(20); join_none
         // Polling resumes first, else the stale timeout retrips
         cyc(15);
         i_mdl.request(0);
         cyc(6);
         expect_true(tripped === 1'b0, "control bit");
         linkMode = LINK_NONE;
         cyc(200);
      end
   endtask : link_watch
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   initial begin
      rst = 1'b1;
      faultsIn = '0;
      linkMode = LINK_NONE;
      cyc(6);
      rst = 1'b0;
      cyc(4);
      expect_true(faultCode === 8'h00, "idle");
      code_table();
      lockout_ladder();
      power_in_lockout();
      link_watch();
      tally_and_finish();
   end
endmodule : dftr_trip_manager_tb_top
`default_nettype wire
